//--- verilog/drfs_ctrl.sv
// Controller end: refresh debt scheduler honouring rate-dependent limits.
// Assumes user requests are held until o_req_ready; one command a cycle.
`timescale 1ns/1ps
`include "drfs_params.svh"
// How it works
// - refresh only idle banks.
// - other banks usable during pb spacing.
// - other banks usable during pb cycle.
// - one refresh per interval on average.
// - at most eight refreshes postponed.
// - eight postponed gives nine-interval gap.
// - pulled-in credit capped at eight.
// - at most sixteen refreshes per two intervals.
// - postponed total across self refresh capped eight.
// - debt tally frozen during self refresh; window keeps rolling.
// - per-bank budget eight times all-bank.
// - rate field encodes interval multiplier.
// - legacy limits eight and sixteen.
// - modified limits for four and two times.
// - reduce backlog steadily after rate change.
// - clear pulled-in tally on new phase.
// - refresh at reported or shorter period.
// - read then precharge time before pb refresh.
// - burst 32 adds eight cycles.
// - extra refresh between self refresh exit, entry.
// - all-bank refresh resets pb pointer.
// - 8192 refreshes per window at base rate.
module drfs_ctrl
  import drfs_pkg::*;
  #(parameter int REFI_CYC = `DRFS_REFI_CYC,
    parameter bit MODIFIED = 1'b1)
  (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_req_valid,
  input  wire drfs_cmd_t  i_req_cmd,
  input  wire logic [2:0] i_req_bank,
  input  wire logic       i_req_bl32,
  input  wire logic       i_use_per_bank,
  drfs_if.ctrl            link,
  output logic            o_req_ready,
  output logic signed [4:0] o_debt,
  output logic [2:0]      o_pb_ptr
  );
  logic [15:0] refi_cnt_r;
  logic signed [4:0] debt_r;
  logic [2:0]  pb_ptr_r;
  logic [2:0]  rate_r;
  logic [7:0]  open_r;
  logic [4:0]  rd_wait_r [8];
  logic [4:0]  win_r;
  logic [15:0] win_cnt_r;
  logic [4:0]  win_prev_r;
  logic        sr_r;
  logic        need_extra_r;
  logic        ref_busy_r;
  logic [4:0]  ref_tmr_r;
  // Scaled interval: rate multiplier applied by multiply or divide.
  wire [2:0] rate = link.refresh_rate_field;
  wire [15:0] refi_scaled =
    (rate == `DRFS_RATE_X4) ? 16'(REFI_CYC * 4) :
    (rate == `DRFS_RATE_X2) ? 16'(REFI_CYC * 2) :
    (rate == `DRFS_RATE_HALF) ? 16'(REFI_CYC / 2) :
    (rate == `DRFS_RATE_QTR_A || rate == `DRFS_RATE_QTR_B) ?
      16'(REFI_CYC / 4) : 16'(REFI_CYC);
  // Per-bank mode owes eight commands per interval, so the debt tally and
  // the window both run on an eighth of the scaled interval.
  wire [15:0] refi_eff = i_use_per_bank ?
    (refi_scaled >> `DRFS_PB_SHIFT) : refi_scaled;
  wire [4:0] lim =
    (MODIFIED && rate == `DRFS_RATE_X4) ? 5'(`DRFS_MOD_X4_DEBT) :
    (MODIFIED && rate == `DRFS_RATE_X2) ? 5'(`DRFS_MOD_X2_DEBT) :
    5'(`DRFS_MAX_DEBT);
  wire [4:0] win_lim =
    (MODIFIED && rate == `DRFS_RATE_X4) ? 5'(`DRFS_MOD_X4_WIN) :
    (MODIFIED && rate == `DRFS_RATE_X2) ? 5'(`DRFS_MOD_X2_WIN) :
    5'(`DRFS_WIN_MAX);
  wire tick = refi_cnt_r >= refi_eff - 16'h0001;
  // The tally saturates, so a refresh held off by open rows never wraps it.
  wire inc  = tick && debt_r != `DRFS_DEBT_SAT;
  wire win_ok = (win_r + win_prev_r) < win_lim;
  wire pb_idle = !open_r[pb_ptr_r] && rd_wait_r[pb_ptr_r] == 5'h00
                 && !link.bank_busy[pb_ptr_r];
  wire all_idle = open_r == 8'h00 && link.bank_busy == 8'h00;
  wire can_ref = !sr_r && !ref_busy_r && win_ok &&
                 (i_use_per_bank ? pb_idle : all_idle);
  // Urgent when debt hits limit; opportunistic pull-in while idle.
  wire urgent = debt_r >= $signed(lim) || need_extra_r;
  wire pull   = !i_req_valid && debt_r > -$signed(5'(`DRFS_MAX_DEBT));
  wire do_ref = can_ref && (urgent || pull);
  // A precharge still passes while a refresh is overdue; an open row would
  // otherwise hold off the very refresh that is blocking it.
  wire pre_req = i_req_valid && i_req_cmd == DRFS_CMD_PRE;
  wire blk = (urgent && !pre_req) ||
             (i_req_valid && i_req_cmd == DRFS_CMD_SR_ENTRY
             && (need_extra_r || debt_r > $signed(lim)));
  // In self refresh only the exit request is ever taken.
  assign o_req_ready = !do_ref && !blk && !sr_r ? 1'b1 :
                       (sr_r && i_req_cmd == DRFS_CMD_SR_EXIT);
  wire issue = i_req_valid && o_req_ready;
  wire is_rd = issue && i_req_cmd == DRFS_CMD_RD;
  wire rate_chg = rate != rate_r;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      link.cmd <= DRFS_CMD_NOP;
      link.bank <= 3'h0;
      link.bl32 <= 1'b0;
    end else if (do_ref) begin
      link.cmd <= i_use_per_bank ? DRFS_CMD_REF_PB : DRFS_CMD_REF_AB;
      link.bank <= pb_ptr_r;
      link.bl32 <= 1'b0;
    end else begin
      link.cmd <= issue ? i_req_cmd : DRFS_CMD_NOP;
      link.bank <= i_req_bank;
      link.bl32 <= i_req_bl32;
    end
  end
  // Row and read-spacing state per bank, taken from requests as they issue.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bank
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          open_r[g] <= 1'b0;
          rd_wait_r[g] <= 5'h00;
        end else begin
          if (issue && i_req_bank == 3'(g) && i_req_cmd == DRFS_CMD_ACT)
            open_r[g] <= 1'b1;
          else if (issue && i_req_bank == 3'(g) &&
                   i_req_cmd == DRFS_CMD_PRE)
            open_r[g] <= 1'b0;
          if (is_rd && i_req_bank == 3'(g))
            rd_wait_r[g] <= 5'(`DRFS_RD_PB_CYC) + (i_req_bl32 ?
              5'(`DRFS_BL32_EXTRA_CYC) : 5'h00);
          else if (rd_wait_r[g] != 5'h00)
            rd_wait_r[g] <= rd_wait_r[g] - 5'h01;
        end
      end
    end
  endgenerate
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      refi_cnt_r <= 16'h0000;
      debt_r <= 5'sh00;
      pb_ptr_r <= 3'h0;
      rate_r <= `DRFS_RATE_X1;
      win_r <= 5'h00;
      win_prev_r <= 5'h00;
      win_cnt_r <= 16'h0000;
      sr_r <= 1'b0;
      need_extra_r <= 1'b0;
      ref_busy_r <= 1'b0;
      ref_tmr_r <= 5'h00;
    end else begin
      rate_r <= rate;
      if (win_cnt_r >= refi_eff - 16'h0001) begin
        win_cnt_r <= 16'h0000;
        win_prev_r <= win_r;
        win_r <= 5'(do_ref);
      end else begin
        win_cnt_r <= win_cnt_r + 16'h0001;
        if (do_ref)
          win_r <= win_r + 5'h01;
      end
      // Debt freezes while in self refresh.
      if (!sr_r) begin
        refi_cnt_r <= tick ? 16'h0000 : refi_cnt_r + 16'h0001;
        // A new thermal phase drops pulled-in credit but keeps the backlog.
        if (rate_chg && debt_r < 5'sh00)
          debt_r <= 5'sh00;
        // The extra refresh after self refresh earns no credit.
        else if (do_ref && need_extra_r)
          debt_r <= debt_r + (inc ? 5'sh01 : 5'sh00);
        else
          debt_r <= debt_r + (inc ? 5'sh01 : 5'sh00)
                    - (do_ref ? 5'sh01 : 5'sh00);
      end
      if (do_ref)
        need_extra_r <= 1'b0;
      if (do_ref && !i_use_per_bank)
        pb_ptr_r <= 3'h0;
      else if (do_ref)
        pb_ptr_r <= pb_ptr_r + 3'h1;
      else if (issue && i_req_cmd == DRFS_CMD_SR_EXIT)
        pb_ptr_r <= 3'h0;
      if (issue && i_req_cmd == DRFS_CMD_SR_ENTRY)
        sr_r <= 1'b1;
      else if (issue && i_req_cmd == DRFS_CMD_SR_EXIT) begin
        sr_r <= 1'b0;
        need_extra_r <= 1'b1;
      end
      // Any refresh holds off the next one until its per-bank or all-bank refresh timer runs out.
      if (do_ref) begin
        ref_busy_r <= 1'b1;
        ref_tmr_r <= i_use_per_bank ? 5'(`DRFS_RFCPB_CYC) :
                     5'(`DRFS_RFCAB_CYC);
      end else if (ref_tmr_r != 5'h00)
        ref_tmr_r <= ref_tmr_r - 5'h01;
      else
        ref_busy_r <= 1'b0;
    end
  end
  assign o_debt = debt_r;
  assign o_pb_ptr = pb_ptr_r;
endmodule : drfs_ctrl

//--- verilog/drfs_params.svh
// Named constants for the refresh scheduling pair: timing, limits, encodings.
// Assumes a 100 MHz clock; included by the package and both ends.
`ifndef DRFS_PARAMS_SVH
`define DRFS_PARAMS_SVH
`define DRFS_CLK_PERIOD_NS     10
`define DRFS_REFI_NS           3904
`define DRFS_REFI_CYC          (`DRFS_REFI_NS / `DRFS_CLK_PERIOD_NS)
`define DRFS_RFCAB_NS          180
`define DRFS_RFCAB_CYC         \
  ((`DRFS_RFCAB_NS + `DRFS_CLK_PERIOD_NS - 1) / `DRFS_CLK_PERIOD_NS)
`define DRFS_RFCPB_NS          90
`define DRFS_RFCPB_CYC         \
  ((`DRFS_RFCPB_NS + `DRFS_CLK_PERIOD_NS - 1) / `DRFS_CLK_PERIOD_NS)
`define DRFS_RTP_NS            8
`define DRFS_RPPB_NS           18
`define DRFS_RD_PB_CYC         \
  ((`DRFS_RTP_NS + `DRFS_RPPB_NS + `DRFS_CLK_PERIOD_NS - 1) \
   / `DRFS_CLK_PERIOD_NS)
`define DRFS_BL32_EXTRA_CYC    8
`define DRFS_MAX_DEBT          8
`define DRFS_WIN_MAX           16
`define DRFS_RATE_LOW          3'h0
`define DRFS_RATE_X4           3'h1
`define DRFS_RATE_X2           3'h2
`define DRFS_RATE_X1           3'h3
`define DRFS_RATE_HALF         3'h4
`define DRFS_RATE_QTR_A        3'h5
`define DRFS_RATE_QTR_B        3'h6
`define DRFS_RATE_HIGH         3'h7
`define DRFS_MOD_X4_DEBT       2
`define DRFS_MOD_X4_WIN        4
`define DRFS_MOD_X2_DEBT       4
`define DRFS_MOD_X2_WIN        8
`define DRFS_PB_SHIFT          3
`define DRFS_DEBT_SAT          5'sh0f
`endif

//--- verilog/drfs_pkg.sv
// Types shared by both ends of the refresh link.
// Assumes drfs_params.svh is on the include path.
`include "drfs_params.svh"
package drfs_pkg;
  typedef enum logic [2:0] {
    DRFS_CMD_NOP, DRFS_CMD_ACT, DRFS_CMD_RD, DRFS_CMD_PRE,
    DRFS_CMD_REF_AB, DRFS_CMD_REF_PB, DRFS_CMD_SR_ENTRY, DRFS_CMD_SR_EXIT
  } drfs_cmd_t;
endpackage : drfs_pkg

//--- verilog/drfs_if.sv
// Command/address link between controller and device, single clock.
// Assumes both ends share the clock; commands valid for one cycle.
`timescale 1ns/1ps
interface drfs_if
  import drfs_pkg::*;
  (input wire logic i_clk);
  drfs_cmd_t  cmd;
  logic [2:0] bank;
  logic       bl32;
  logic [2:0] refresh_rate_field;
  logic [7:0] bank_busy;
  modport ctrl (output cmd, output bank, output bl32,
                input refresh_rate_field, input bank_busy);
  modport dev  (input cmd, input bank, input bl32,
                output refresh_rate_field, output bank_busy);
endinterface : drfs_if

//--- verilog/drfs_dev.sv
// Device end: per-bank refresh pointer, per-bank busy timers, rate field.
// Assumes the controller honours its own scheduling limits.
`timescale 1ns/1ps
`include "drfs_params.svh"
module drfs_dev
  import drfs_pkg::*;
  #(parameter int NBANK = 8)
  (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [2:0] i_rate,
  drfs_if.dev             link,
  output logic [2:0]      o_pb_ptr,
  output logic            o_in_self_refresh,
  output logic            o_cmd_rejected
  );
  typedef logic [7:0] drfs_tmr_t;
  drfs_tmr_t  tmr_r [NBANK];
  logic [NBANK-1:0] busy_w;
  logic [2:0] ptr_r;
  logic       sr_r;
  logic       rej_r;
  wire is_ab  = link.cmd == DRFS_CMD_REF_AB;
  wire is_pb  = link.cmd == DRFS_CMD_REF_PB;
  wire is_acc = link.cmd == DRFS_CMD_ACT || link.cmd == DRFS_CMD_RD;
  // Only the addressed bank's busy timer blocks ACT or RD; an all-bank refresh makes all eight busy.
  wire rej_nxt = is_acc && busy_w[link.bank];
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      assign busy_w[g] = tmr_r[g] != '0;
      always_ff @(posedge i_clk) begin
        if (!i_rst_n)
          tmr_r[g] <= '0;
        else if (is_ab)
          tmr_r[g] <= 8'(`DRFS_RFCAB_CYC);
        else if (is_pb && link.bank == 3'(g))
          tmr_r[g] <= 8'(`DRFS_RFCPB_CYC);
        else if (busy_w[g])
          tmr_r[g] <= tmr_r[g] - 8'h01;
      end
    end
  endgenerate
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ptr_r <= 3'h0;
      sr_r  <= 1'b0;
      rej_r <= 1'b0;
    end else begin
      rej_r <= rej_nxt;
      if (is_ab || link.cmd == DRFS_CMD_SR_EXIT)
        ptr_r <= 3'h0;
      else if (is_pb)
        ptr_r <= ptr_r + 3'h1;
      if (link.cmd == DRFS_CMD_SR_ENTRY)
        sr_r <= 1'b1;
      else if (link.cmd == DRFS_CMD_SR_EXIT)
        sr_r <= 1'b0;
    end
  end
  assign link.refresh_rate_field = i_rate;
  assign link.bank_busy          = busy_w;
  assign o_pb_ptr                = ptr_r;
  assign o_in_self_refresh       = sr_r;
  assign o_cmd_rejected          = rej_r;
endmodule : drfs_dev

//--- bench/drfs_link_props.sv
// Checker on the refresh link between controller and device ends.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "drfs_params.svh"
module drfs_link_chk
  import drfs_pkg::*;
  #(parameter int REFI_CYC = 40)
  (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire drfs_cmd_t  cmd,
  input wire logic [2:0] bank,
  input wire logic       bl32,
  input wire logic [2:0] refresh_rate_field,
  input wire logic [7:0] bank_busy
  );
  localparam int RDPB = `DRFS_RD_PB_CYC;
  localparam int RD32 = RDPB + `DRFS_BL32_EXTRA_CYC;
  logic [2:0]  ptr_r;
  logic [2:0]  rdb_r;
  logic        sr_r;
  logic        owe_r;
  logic        l32_r;
  logic [4:0]  rdc_r;
  logic [15:0] gap_r;
  wire is_ref = cmd == DRFS_CMD_REF_AB || cmd == DRFS_CMD_REF_PB;
  // The gap only counts at the base rate and outside self refresh.
  wire gap_clr = is_ref || sr_r || refresh_rate_field != `DRFS_RATE_X1;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ptr_r <= 3'h0;
      rdb_r <= 3'h0;
      sr_r  <= 1'b0;
      owe_r <= 1'b0;
      l32_r <= 1'b0;
      rdc_r <= 5'h1f;
      gap_r <= 16'h0000;
    end else begin
      if (cmd == DRFS_CMD_REF_AB || cmd == DRFS_CMD_SR_EXIT)
        ptr_r <= 3'h0;
      else if (cmd == DRFS_CMD_REF_PB) ptr_r <= ptr_r + 3'h1;
      if (cmd == DRFS_CMD_SR_ENTRY) sr_r <= 1'b1;
      else if (cmd == DRFS_CMD_SR_EXIT) sr_r <= 1'b0;
      if (cmd == DRFS_CMD_SR_EXIT) owe_r <= 1'b1;
      else if (is_ref) owe_r <= 1'b0;
      if (cmd == DRFS_CMD_RD) begin
        rdc_r <= 5'h01;
        rdb_r <= bank;
        l32_r <= bl32;
      end else if (rdc_r != 5'h1f) rdc_r <= rdc_r + 5'h01;
      gap_r <= gap_clr ? 16'h0000 : gap_r + 16'h0001;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  all_bank_refresh_idle_a: assert property (
    cmd == DRFS_CMD_REF_AB |-> bank_busy == 8'h00)
    else $error("all-bank refresh with a busy bank");
  pb_idle_a: assert property (
    cmd == DRFS_CMD_REF_PB |-> !bank_busy[bank])
    else $error("per-bank refresh to a busy bank");
  pb_only_a: assert property (
    cmd == DRFS_CMD_REF_PB && bank_busy == 8'h00
    |=> bank_busy == (8'h01 << $past(bank)))
    else $error("per-bank refresh blocked the wrong banks");
  pb_order_a: assert property (
    cmd == DRFS_CMD_REF_PB |-> bank == ptr_r)
    else $error("per-bank refresh off the pointer");
  sr_quiet_a: assert property (
    sr_r |-> cmd inside {DRFS_CMD_NOP, DRFS_CMD_SR_EXIT})
    else $error("command issued inside self refresh");
  sr_extra_a: assert property (
    cmd == DRFS_CMD_SR_ENTRY |-> !owe_r)
    else $error("self refresh entered without extra refresh");
  rd_pb_a: assert property (
    cmd == DRFS_CMD_REF_PB && bank == rdb_r
    |-> rdc_r >= (l32_r ? RD32 : RDPB))
    else $error("per-bank refresh too soon after read");
  gap_max_a: assert property (
    gap_r <= 9 * REFI_CYC + 2)
    else $error("refresh gap above nine intervals");
endmodule : drfs_link_chk

//--- bench/tb_top.sv
// Bench joining controller and device ends over the link interface.
// Assumes the package, header and interface are compiled first.
`timescale 1ns/1ps
module tb_top;
  import drfs_pkg::*;
  // Long enough that per-bank refreshes, an eighth of it apart, keep up.
  localparam int REFI = 160;
  localparam int LIM  = 20 * REFI;
  logic              i_clk, i_rst_n, vld, bl32, pbm, insr, rej, rdy;
  drfs_cmd_t         rcmd;
  logic [2:0]        rbank, rate, dptr, cptr, b;
  logic signed [4:0] debt, d0;
  int                bad_count, n_checks;
  drfs_if link (.i_clk(i_clk));
  drfs_dev drfs_dev_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rate(rate),
    .link(link), .o_pb_ptr(dptr), .o_in_self_refresh(insr),
    .o_cmd_rejected(rej));
  drfs_ctrl #(.REFI_CYC(REFI)) drfs_ctrl_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_req_valid(vld), .i_req_cmd(rcmd),
    .i_req_bank(rbank), .i_req_bl32(bl32), .i_use_per_bank(pbm),
    .link(link), .o_req_ready(rdy), .o_debt(debt), .o_pb_ptr(cptr));
  drfs_link_chk #(.REFI_CYC(REFI)) drfs_link_chk_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .cmd(link.cmd), .bank(link.bank), .bl32(link.bl32),
    .refresh_rate_field(link.refresh_rate_field),
    .bank_busy(link.bank_busy));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic ck(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      bad_count++;
      $display("[FAIL] t=%0t %s", $time, m);
    end
  endtask : ck
  task automatic wait_cmd(input drfs_cmd_t c);
    for (int i = 0; i < LIM; i++) begin
      @(posedge i_clk);
      if (link.cmd === c) return;
    end
    ck(1'b0, "no such command seen");
    report_and_stop();
  endtask : wait_cmd
  // Request is held until ready is sampled high at a rising edge. Valid is
  // left up so a back-to-back call sets it once; the caller drops it.
  task automatic req(input drfs_cmd_t c, input logic [2:0] bk, input bit l);
    int i;
    rcmd = c;
    rbank = bk;
    bl32 = l;
    vld = 1'b1;
    for (i = 0; i < LIM; i++) begin
      @(posedge i_clk);
      if (rdy === 1'b1) break;
    end
    #1;
    if (i == LIM) begin
      ck(1'b0, "request never taken");
      report_and_stop();
    end
  endtask : req
  task automatic t_rate();
    for (int r = 0; r < 8; r++) begin
      rate = r[2:0];
      @(posedge i_clk);
      #1 ck(link.refresh_rate_field === r[2:0], "rate field");
    end
    rate = 3'h3;
  endtask : t_rate
  task automatic t_cadence();
    wait_cmd(DRFS_CMD_REF_AB);
    repeat (12 * REFI) @(posedge i_clk);
    #1 ck(debt >= -5'sd8 && debt <= 5'sd8, "debt out of range");
  endtask : t_cadence
  task automatic t_pointer();
    pbm = 1'b1;
    repeat (9) begin
      wait_cmd(DRFS_CMD_REF_PB);
      #1 ck(dptr === cptr, "pointers differ");
    end
    pbm = 1'b0;
    wait_cmd(DRFS_CMD_REF_AB);
    #1 ck(dptr === 3'h0 && cptr === 3'h0, "pointer not cleared");
  endtask : t_pointer
  // A row opened in the next bank while the current one refreshes.
  task automatic t_other_bank();
    pbm = 1'b1;
    wait_cmd(DRFS_CMD_REF_PB);
    b = link.bank + 3'h1;
    #1 req(DRFS_CMD_ACT, b, 1'b0);
    req(DRFS_CMD_RD, b, 1'b1);
    vld = 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      #1 ck(rej === 1'b0, "other bank refused");
    end
    req(DRFS_CMD_PRE, b, 1'b0);
    vld = 1'b0;
    wait_cmd(DRFS_CMD_REF_PB);
    #1 pbm = 1'b0;
  endtask : t_other_bank
  task automatic t_self_ref();
    req(DRFS_CMD_SR_ENTRY, 3'h0, 1'b0);
    vld = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 ck(insr === 1'b1, "self refresh not entered");
    d0 = debt;
    repeat (3 * REFI) @(posedge i_clk);
    #1 ck(debt === d0, "debt moved in self refresh");
    req(DRFS_CMD_SR_EXIT, 3'h0, 1'b0);
    vld = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 ck(insr === 1'b0, "self refresh not left");
    req(DRFS_CMD_SR_ENTRY, 3'h0, 1'b0);
    req(DRFS_CMD_SR_EXIT, 3'h0, 1'b0);
    vld = 1'b0;
  endtask : t_self_ref
  initial begin
    i_rst_n = 1'b0;
    vld = 1'b0;
    bl32 = 1'b0;
    pbm = 1'b0;
    rate = 3'h3;
    rcmd = DRFS_CMD_NOP;
    rbank = 3'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (12) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    t_rate();
    t_cadence();
    t_pointer();
    t_other_bank();
    t_self_ref();
    report_and_stop();
  end
endmodule : tb_top
